// ===== pkg/tab_map.vh
// register map, field positions and reset values of the ability register bank
`ifndef TAB_MAP_VH
`define TAB_MAP_VH

// register offsets, at the management register port
`define TAB_OFS_ADV_UPPER 16'h0204
`define TAB_OFS_LP_LOW 16'h0205
`define TAB_OFS_LP_MID 16'h0206
`define TAB_OFS_LP_HIGH 16'h0207

// reset values
`define TAB_RST_ADV_UPPER 16'h0000
`define TAB_RST_LP_WORD 16'h0000

// local advertisement, upper word
`define TAB_BIT_HI_ABL 13
`define TAB_BIT_HI_REQ 12

// partner base page, low word
`define TAB_BIT_LP_NEXT_PAGE 15
`define TAB_BIT_LP_ACK 14
`define TAB_BIT_LP_FAULT 13
`define TAB_BIT_LP_FORCE 12
`define TAB_FLD_LP_PAUSE_HI 11
`define TAB_FLD_LP_PAUSE_LO 10
`define TAB_FLD_LP_SEL_HI 4
`define TAB_FLD_LP_SEL_LO 0

// partner base page, middle word
`define TAB_BIT_LP_LEADER 4

// partner base page, high word
`define TAB_BIT_LP_HI_ABL 13
`define TAB_BIT_LP_HI_REQ 12

// implemented bits; reserved bits read as zero
`define TAB_MASK_ADV_UPPER 16'h3000
`define TAB_MASK_LP_LOW 16'hfc1f
`define TAB_MASK_LP_MID 16'h40f0
`define TAB_MASK_LP_HIGH 16'h7800

`endif

// ===== rtl/tab_strap_latch.v
// catches the transmit-level straps once, at the first edge after reset release
`timescale 1ns/1ps
`default_nettype none

module tab_strap_latch (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // strap pins
  input wire strap_hi_abl_i,
  input wire strap_hi_req_i,
  // captured values
  output reg load_o,
  output reg hi_abl_o,
  output reg hi_req_o
);

  reg done_r;

  // the async reset may only load constants, so the pins are sampled after release
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_r <= 1'b0;
      load_o <= 1'b0;
      hi_abl_o <= 1'b0;
      hi_req_o <= 1'b0;
    end
    else
    begin
      load_o <= 1'b0;
      if (!done_r)
      begin
        done_r <= 1'b1;
        load_o <= 1'b1;
        hi_abl_o <= strap_hi_abl_i;
        hi_req_o <= strap_hi_req_i;
      end
    end
  end

endmodule // tab_strap_latch

`default_nettype wire

// ===== rtl/tab_tx_level_resolve.v
// resolves the transmit amplitude from local and partner high-level bits
`timescale 1ns/1ps
`default_nettype none

module tab_tx_level_resolve (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // local advertisement
  input wire loc_abl_i,
  input wire loc_req_i,
  // partner advertisement
  input wire lp_valid_i,
  input wire lp_abl_i,
  input wire lp_req_i,
  // result: 1 high level, 0 low level
  output reg level_high_o
);

  // low level until a partner page is in hand: safe for any partner
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      level_high_o <= 1'b0;
    end
    else if (!lp_valid_i || !loc_abl_i || !lp_abl_i)
    begin
      level_high_o <= 1'b0;
    end
    else
    begin
      level_high_o <= loc_req_i | lp_req_i;
    end
  end

endmodule // tab_tx_level_resolve

`default_nettype wire

// ===== rtl/tab_ability_regs.v
// autonegotiation ability register bank: local upper advertisement and partner base page
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tab_map.vh"

module tab_ability_regs (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // register port
  input wire [15:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // strap pins
  input wire strap_hi_abl_i,
  input wire strap_hi_req_i,
  // received base page from the autonegotiation receiver
  input wire an_restart_i,
  input wire lp_page_valid_i,
  input wire [47:0] lp_page_i,
  // local advertisement towards the autonegotiation transmitter
  output wire adv_hi_abl_o,
  output wire adv_hi_req_o,
  // resolved transmit level
  output wire tx_level_high_o,
  // partner state towards the rest of the phy
  output reg lp_page_seen_o,
  output wire partner_more_pages_flag_o,
  output wire partner_codeword_acknowledged_o,
  output wire partner_far_fault_o,
  output wire partner_role_forced_o,
  output wire partner_role_leader_o,
  output wire [1:0] partner_flow_pause_ability_o
);

  // address match, shared by write, read and snapshot decode
  function hit;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  wire strap_load;
  wire strap_abl;
  wire strap_req;
  wire adv_wr;
  wire low_rd;
  wire [31:0] live_up;
  wire [15:0] snap_mid;
  wire [15:0] snap_high;

  reg hi_abl_r;
  reg hi_req_r;
  reg [15:0] lp_low_r;
  reg [15:0] lp_mid_r;
  reg [15:0] lp_high_r;
  reg [15:0] snap_r [0:1];
  reg [15:0] rdata_nxt;

  // whole-word reset value, so each bit can be picked out at its own width
  localparam [15:0] ADV_RST_VAL = `TAB_RST_ADV_UPPER;

  tab_strap_latch u_strap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .strap_hi_abl_i(strap_hi_abl_i),
    .strap_hi_req_i(strap_hi_req_i),
    .load_o(strap_load),
    .hi_abl_o(strap_abl),
    .hi_req_o(strap_req)
  );

  assign adv_wr = reg_wr_i & hit(reg_addr_i, `TAB_OFS_ADV_UPPER);
  assign low_rd = reg_rd_i & hit(reg_addr_i, `TAB_OFS_LP_LOW);

  // local high-level bits; strap value becomes the effective reset value
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hi_abl_r <= ADV_RST_VAL[`TAB_BIT_HI_ABL];
      hi_req_r <= ADV_RST_VAL[`TAB_BIT_HI_REQ];
    end
    else if (strap_load)
    begin
      hi_abl_r <= strap_abl;
      hi_req_r <= strap_req;
    end
    else if (adv_wr)
    begin
      hi_abl_r <= reg_wdata_i[`TAB_BIT_HI_ABL];
      hi_req_r <= reg_wdata_i[`TAB_BIT_HI_REQ];
    end
  end

  assign adv_hi_abl_o = hi_abl_r;
  assign adv_hi_req_o = hi_req_r;

  // live partner words; no write path reaches them, so host writes drop silently
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lp_low_r <= `TAB_RST_LP_WORD;
      lp_mid_r <= `TAB_RST_LP_WORD;
      lp_high_r <= `TAB_RST_LP_WORD;
      lp_page_seen_o <= 1'b0;
    end
    else if (an_restart_i)
    begin
      lp_low_r <= `TAB_RST_LP_WORD;
      lp_mid_r <= `TAB_RST_LP_WORD;
      lp_high_r <= `TAB_RST_LP_WORD;
      lp_page_seen_o <= 1'b0;
    end
    else if (lp_page_valid_i)
    begin
      lp_low_r <= lp_page_i[15:0] & `TAB_MASK_LP_LOW;
      lp_mid_r <= lp_page_i[31:16] & `TAB_MASK_LP_MID;
      lp_high_r <= lp_page_i[47:32] & `TAB_MASK_LP_HIGH;
      lp_page_seen_o <= 1'b1;
    end
  end

  assign partner_more_pages_flag_o = lp_low_r[`TAB_BIT_LP_NEXT_PAGE];
  assign partner_codeword_acknowledged_o = lp_low_r[`TAB_BIT_LP_ACK];
  assign partner_far_fault_o = lp_low_r[`TAB_BIT_LP_FAULT];
  assign partner_role_forced_o = lp_low_r[`TAB_BIT_LP_FORCE];
  assign partner_role_leader_o = lp_mid_r[`TAB_BIT_LP_LEADER];
  assign partner_flow_pause_ability_o = lp_low_r[`TAB_FLD_LP_PAUSE_HI:`TAB_FLD_LP_PAUSE_LO];

  // snapshot of middle and high words taken at the low-word read; a page landing
  // in the same cycle is missed by both the read and the snapshot, so the set stays coherent
  assign live_up = {lp_high_r, lp_mid_r};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_snap
      always @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          snap_r[g] <= `TAB_RST_LP_WORD;
        end
        else if (low_rd)
        begin
          snap_r[g] <= live_up[g*16 +: 16];
        end
      end
    end
  endgenerate

  assign snap_mid = snap_r[0];
  assign snap_high = snap_r[1];

  // read mux; unmapped offsets read zero
  always @*
  begin
    rdata_nxt = 16'h0000;
    if (hit(reg_addr_i, `TAB_OFS_ADV_UPPER))
    begin
      rdata_nxt[`TAB_BIT_HI_ABL] = hi_abl_r;
      rdata_nxt[`TAB_BIT_HI_REQ] = hi_req_r;
    end
    else if (hit(reg_addr_i, `TAB_OFS_LP_LOW))
    begin
      rdata_nxt = lp_low_r;
    end
    else if (hit(reg_addr_i, `TAB_OFS_LP_MID))
    begin
      rdata_nxt = snap_mid;
    end
    else if (hit(reg_addr_i, `TAB_OFS_LP_HIGH))
    begin
      rdata_nxt = snap_high;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rdata_nxt;
    end
    else
    begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // amplitude follows the live partner page, not the host snapshot
  tab_tx_level_resolve u_level (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .loc_abl_i(hi_abl_r),
    .loc_req_i(hi_req_r),
    .lp_valid_i(lp_page_seen_o),
    .lp_abl_i(lp_high_r[`TAB_BIT_LP_HI_ABL]),
    .lp_req_i(lp_high_r[`TAB_BIT_LP_HI_REQ]),
    .level_high_o(tx_level_high_o)
  );

endmodule // tab_ability_regs

`default_nettype wire

// ===== bench/tab_regs_sva.sv
// checker of the ability register bank
`timescale 1ns/1ps
`default_nettype none
module tab_regs_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // partner page
  input wire logic an_restart_i,
  input wire logic lp_page_valid_i,
  input wire logic [47:0] lp_page_i,
  // status
  input wire logic adv_hi_abl_o,
  input wire logic adv_hi_req_o,
  input wire logic tx_level_high_o,
  input wire logic partner_more_pages_flag_o,
  input wire logic partner_far_fault_o,
  input wire logic partner_role_leader_o,
  input wire logic [1:0] partner_flow_pause_ability_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic take = lp_page_valid_i && !an_restart_i;
  a_adv_write: assert property (reg_wr_i && reg_addr_i == 16'h0204
    |=> {adv_hi_abl_o, adv_hi_req_o} == $past(reg_wdata_i[13:12])) else $error("adv lost");
  a_level_low: assert property (!adv_hi_abl_o |=> !tx_level_high_o)
    else $error("level not low");
  a_level_lp_low: assert property (take && !lp_page_i[45] ##1 !lp_page_valid_i
    |=> !tx_level_high_o) else $error("level not low");
  a_level_high: assert property (take && lp_page_i[45] && lp_page_i[44] ##1
    adv_hi_abl_o && !an_restart_i |=> tx_level_high_o) else $error("level not high");
  a_low_read: assert property (reg_rd_i && reg_addr_i == 16'h0205 |=>
    {reg_rdata_o[15], reg_rdata_o[13], reg_rdata_o[11:10]} == $past({partner_more_pages_flag_o,
    partner_far_fault_o, partner_flow_pause_ability_o})) else $error("low word differs");
  a_snap_mid: assert property (reg_rd_i && reg_addr_i == 16'h0205 ##1
    reg_rd_i && reg_addr_i == 16'h0206 |=> reg_rdata_o[4] == $past(partner_role_leader_o, 2))
    else $error("snapshot differs");
  a_lp_load: assert property (take |=> partner_role_leader_o == $past(lp_page_i[20]) &&
    partner_flow_pause_ability_o == $past(lp_page_i[11:10])) else $error("page not loaded");
  a_ro_write: assert property (reg_wr_i && !lp_page_valid_i && !an_restart_i |=>
    $stable({partner_more_pages_flag_o, partner_role_leader_o})) else $error("partner written");
  cover property (take ##1 reg_rd_i);
  cover property (tx_level_high_o);
  cover property (reg_wr_i && reg_addr_i == 16'h0206);
endmodule // tab_regs_sva
bind tab_ability_regs tab_regs_sva tab_regs_sva_i (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .an_restart_i, .lp_page_valid_i, .lp_page_i, .adv_hi_abl_o,
  .adv_hi_req_o, .tx_level_high_o, .partner_more_pages_flag_o, .partner_far_fault_o,
  .partner_role_leader_o, .partner_flow_pause_ability_o);
`default_nettype wire

// ===== bench/tab_lp_model.sv
// remote link partner: delivers one received base page on request
`timescale 1ns/1ps
`default_nettype none
module tab_lp_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // test control
  input wire logic send_i,
  input wire logic [47:0] word_i,
  // page towards the bank
  output logic lp_page_valid_o,
  output logic [47:0] lp_page_o
);
  // outside the valid pulse the lines toggle, so a stale page never looks good
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      lp_page_valid_o <= 1'h0;
      lp_page_o <= 48'h0;
    end
    else
    begin
      lp_page_valid_o <= send_i;
      lp_page_o <= send_i ? word_i : ~lp_page_o;
    end
endmodule // tab_lp_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking testbench of the ability register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic an_restart_i = 1'h0, send = 1'h0, pend = 1'h0;
  logic [15:0] reg_addr_i = 16'h0, reg_wdata_i = 16'h0, e;
  logic [47:0] word = 48'h0, a, b;
  logic [15:0] q[$];
  int bad_count = 0, tests_run = 0, seed = 33420, cyc = 0;
  wire [15:0] reg_rdata_o;
  wire [47:0] lp_page_i;
  wire [1:0] partner_flow_pause_ability_o;
  wire lp_page_valid_i, adv_hi_abl_o, adv_hi_req_o, tx_level_high_o, lp_page_seen_o;
  wire partner_more_pages_flag_o, partner_codeword_acknowledged_o, partner_far_fault_o;
  wire partner_role_forced_o, partner_role_leader_o;
  tab_lp_model tab_lp_model_i (.clk_i, .rst_n_i, .send_i(send), .word_i(word),
    .lp_page_valid_o(lp_page_valid_i), .lp_page_o(lp_page_i));
  tab_ability_regs tab_ability_regs_i (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .strap_hi_abl_i(1'h1), .strap_hi_req_i(1'h1), .an_restart_i,
    .lp_page_valid_i, .lp_page_i, .adv_hi_abl_o, .adv_hi_req_o, .tx_level_high_o, .lp_page_seen_o,
    .partner_more_pages_flag_o, .partner_codeword_acknowledged_o, .partner_far_fault_o,
    .partner_role_forced_o, .partner_role_leader_o, .partner_flow_pause_ability_o);
  initial
    forever #50 clk_i = ~clk_i;
  task automatic chk(string n, logic [15:0] x, logic [15:0] s);
    tests_run++;
    if (x !== s)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic idle(int n);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(logic [15:0] ad, logic [15:0] d);
    reg_rd_i <= 1'h0;
    reg_wr_i <= 1'h1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_i);
  endtask
  // expected read data goes on the queue; the watcher below compares it a cycle later
  task automatic rd(logic [15:0] ad, logic [15:0] x);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h1;
    reg_addr_i <= ad;
    q.push_back(x);
    @(posedge clk_i);
  endtask
  task automatic page(logic [47:0] w);
    idle(1);
    send <= 1'h1;
    word <= w;
    @(posedge clk_i);
    send <= 1'h0;
    idle(4);
  endtask
  always @(posedge clk_i)
  begin
    if (pend)
      chk("rdata", q.pop_front(), reg_rdata_o);
    pend <= reg_rd_i;
    cyc++;
    if (cyc > 2000)
    begin
      bad_count++;
      summarize;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    idle(2);
    rd(16'h0204, 16'h3000);
    rd(16'h0205, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      e = 16'($random(seed));
      e[13:12] = 2'(i);
      wr(16'h0204, e);
      rd(16'h0204, e & 16'h3000);
      a = 48'({$random(seed), $random(seed)});
      a[45:44] = 2'(i >> 2);
      page(a);
      chk("level", 16'(i[1] & i[3] & (i[0] | i[2])), 16'(tx_level_high_o));
    end
    $display("test level done");
    b = ~a;
    chk("flags", 16'({a[15:10], a[20], 1'h1}), 16'({partner_more_pages_flag_o,
      partner_codeword_acknowledged_o, partner_far_fault_o, partner_role_forced_o,
      partner_flow_pause_ability_o, partner_role_leader_o, lp_page_seen_o}));
    rd(16'h0205, a[15:0] & 16'hfc1f);
    page(b);
    rd(16'h0206, a[31:16] & 16'h40f0);
    rd(16'h0207, a[47:32] & 16'h7800);
    rd(16'h0205, b[15:0] & 16'hfc1f);
    rd(16'h0206, b[31:16] & 16'h40f0);
    wr(16'h0206, 16'hffff);
    wr(16'h0205, 16'hffff);
    wr(16'h0300, 16'hffff);
    rd(16'h0300, 16'h0000);
    rd(16'h0206, b[31:16] & 16'h40f0);
    rd(16'h0205, b[15:0] & 16'hfc1f);
    idle(1);
    an_restart_i <= 1'h1;
    @(posedge clk_i);
    an_restart_i <= 1'h0;
    idle(2);
    chk("restart", 16'h0000, 16'({lp_page_seen_o, partner_role_leader_o}));
    rd(16'h0205, 16'h0000);
    idle(3);
    $display("test snapshot done");
    summarize;
  end
endmodule // testbench
`default_nettype wire
